// *** hdl/wdit_top.v ***
/*
 what: watchdog / interval timer with a classic wishbone register port,
 an overflow pin, a chip reset request and a maskable interrupt.
 assumes: one 100 MHz clock, NRST is the external reset pin, the master
 holds each request until it sees ack.
*/
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
`include "wdit_regs.vh"

module wdit_top #(
   parameter AW = `WDIT_ADDR_W
) (
   // clock and reset
   input wire SYS_CLK,
   input wire NRST,
   // wishbone slave
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [AW-1:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   output reg [31:0] WB_DAT_O,
   output reg WB_ACK_O,
   // timer outputs
   output reg OVERFLOW_OUT_N,
   output reg CHIP_RESET_N,
   output reg INTERVAL_IRQ,
   output reg IRQ
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg [7:0] count;
   reg ovf_flag;
   reg mode;
   reg enable;
   reg [2:0] cks;
   reg watchdog_overflow_flag_flag;
   reg chip_reset_enable;
   reg spare;
   reg arm_ovf;
   reg arm_watchdog_overflow_flag;
   reg cnt_wr_d;
   reg [`WDIT_IRQ_W-1:0] irq_stat;
   reg [`WDIT_IRQ_W-1:0] irq_mask;

   wire tick;
   wire ovf_pulse;
   wire rst_pulse;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire req = WB_CYC_I & WB_STB_I;
   // the access completes at the edge where ack is seen high
   wire done = req & WB_ACK_O;
   wire wr = done & WB_WE_I;
   wire rd = done & ~WB_WE_I;
   wire half = WB_SEL_I[0] & WB_SEL_I[1];
   wire [7:0] key = WB_DAT_I[15:8];
   wire [7:0] low = WB_DAT_I[7:0];
   wire locked = ovf_pulse;

   reg at_tcs;
   reg at_cnt;
   reg at_rcs;
   reg at_pwt;
   reg at_pwr;
   reg at_ist;
   reg at_imk;
   reg wr_cnt;
   reg wr_tcs;
   reg wr_chip_reset_enable;
   reg wr_clrw;

   // one-hot offset decode; unmapped offsets match nothing
   always @* begin
      at_tcs = 1'b0;
      at_cnt = 1'b0;
      at_rcs = 1'b0;
      at_pwt = 1'b0;
      at_pwr = 1'b0;
      at_ist = 1'b0;
      at_imk = 1'b0;
      case (WB_ADR_I)
         `WDIT_OFS_TCS: at_tcs = 1'b1;
         `WDIT_OFS_CNT: at_cnt = 1'b1;
         `WDIT_OFS_RCS: at_rcs = 1'b1;
         `WDIT_OFS_PWT: at_pwt = 1'b1;
         `WDIT_OFS_PWR: at_pwr = 1'b1;
         `WDIT_OFS_IST: at_ist = 1'b1;
         `WDIT_OFS_IMK: at_imk = 1'b1;
         default: at_tcs = 1'b0;
      endcase
   end

   // ordinary writes at the read offsets fall through untouched
   wire pw_ok = wr & half & ~locked;

   // the key picks the target; a wrong key is a silent no-op
   always @* begin
      wr_cnt = 1'b0;
      wr_tcs = 1'b0;
      wr_chip_reset_enable = 1'b0;
      wr_clrw = 1'b0;
      if (pw_ok && at_pwt) begin
         case (key)
            `WDIT_KEY_CNT: wr_cnt = 1'b1;
            `WDIT_KEY_TCS: wr_tcs = 1'b1;
            default: wr_cnt = 1'b0;
         endcase
      end else if (pw_ok && at_pwr) begin
         case (key)
            `WDIT_KEY_CHIP_RESET_ENABLE: wr_chip_reset_enable = 1'b1;
            `WDIT_KEY_CLRW: wr_clrw = 1'b1;
            default: wr_chip_reset_enable = 1'b0;
         endcase
      end
   end

   // ----------------------------------------
   // counting and overflow
   // ----------------------------------------
   wdit_prescale #(
      .DIV_W(`WDIT_DIV_W)
   ) u_pre (
      .clk(SYS_CLK),
      .rst_n(NRST),
      .run(enable),
      .sel(cks),
      .tick(tick)
   );

   // the write wins in its own cycle and in the one after it
   wire inc = tick & enable & ~wr_cnt & ~cnt_wr_d;
   wire wrap = inc & (count == 8'hff);
   wire wdg_wrap = wrap & mode;
   wire ivl_wrap = wrap & ~mode;

   wire [`WDIT_PULSE_W-1:0] ovf_len = chip_reset_enable ? `WDIT_OVF_STATES_RST
                                          : `WDIT_OVF_STATES_NORST;

   wdit_pulse #(
      .W(`WDIT_PULSE_W)
   ) u_ovf (
      .clk(SYS_CLK),
      .rst_n(NRST),
      .start(wdg_wrap),
      .len(ovf_len),
      .active(ovf_pulse)
   );

   wdit_pulse #(
      .W(`WDIT_PULSE_W)
   ) u_crst (
      .clk(SYS_CLK),
      .rst_n(NRST),
      .start(wdg_wrap & chip_reset_enable),
      .len(`WDIT_CHIP_RST_STATES),
      .active(rst_pulse)
   );

   // ----------------------------------------
   // counter
   // ----------------------------------------
   always @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         count <= 8'h00;
         cnt_wr_d <= 1'b0;
      end else begin
         cnt_wr_d <= wr_cnt;
         if (wdg_wrap) begin
            count <= 8'h00;
         end else if (!enable) begin
            count <= 8'h00;
         end else if (wr_cnt) begin
            count <= low;
         end else if (inc) begin
            count <= count + 8'h01;
         end
      end
   end

   // ----------------------------------------
   // timer control / status
   // ----------------------------------------
   // set wins over the clearing write in the same cycle
   always @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         ovf_flag <= 1'b0;
      end else if (wdg_wrap) begin
         // with reset enable this stands for the chip reset clearing it
         ovf_flag <= 1'b0;
      end else if (ivl_wrap) begin
         ovf_flag <= 1'b1;
      end else if (wr_tcs && arm_ovf && !low[`WDIT_FLAG_BIT]) begin
         ovf_flag <= 1'b0;
      end
   end

   // local reset on every watchdog wrap stops the timer
   always @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         mode <= 1'b0;
         enable <= 1'b0;
         cks <= 3'h0;
      end else if (wdg_wrap) begin
         mode <= 1'b0;
         enable <= 1'b0;
         cks <= 3'h0;
      end else if (wr_tcs) begin
         mode <= low[`WDIT_MODE_BIT];
         enable <= low[`WDIT_EN_BIT];
         cks <= low[2:0];
      end
   end

   always @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         arm_ovf <= 1'b0;
      end else if (wdg_wrap) begin
         arm_ovf <= 1'b0;
      end else if (rd && at_tcs && !locked && WB_DAT_O[`WDIT_FLAG_BIT]) begin
         arm_ovf <= 1'b1;
      end else if (wr_tcs || !ovf_flag) begin
         arm_ovf <= 1'b0;
      end
   end

   // ----------------------------------------
   // reset control / status
   // ----------------------------------------
   // only the pin reset reaches these; the chip reset pulse does not
   always @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         watchdog_overflow_flag_flag <= 1'b0;
      end else if (wdg_wrap) begin
         watchdog_overflow_flag_flag <= 1'b1;
      end else if (wr_clrw && arm_watchdog_overflow_flag && !low[`WDIT_FLAG_BIT]) begin
         watchdog_overflow_flag_flag <= 1'b0;
      end
   end

   always @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         chip_reset_enable <= 1'b0;
         spare <= 1'b0;
      end else if (wr_chip_reset_enable) begin
         chip_reset_enable <= low[`WDIT_CHIP_RESET_ENABLE_BIT];
         spare <= low[`WDIT_SPARE_BIT];
      end
   end

   // a read during the overflow pulse does not arm the clear
   always @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         arm_watchdog_overflow_flag <= 1'b0;
      end else if (rd && at_rcs && !locked && WB_DAT_O[`WDIT_FLAG_BIT]) begin
         arm_watchdog_overflow_flag <= 1'b1;
      end else if (wr_clrw || !watchdog_overflow_flag_flag) begin
         arm_watchdog_overflow_flag <= 1'b0;
      end
   end

   // ----------------------------------------
   // interrupt status and mask
   // ----------------------------------------
   wire [`WDIT_IRQ_W-1:0] ev;
   assign ev[`WDIT_IRQ_IVL] = ivl_wrap;
   assign ev[`WDIT_IRQ_WDG] = wdg_wrap;
   wire [`WDIT_IRQ_W-1:0] w1c = (wr && at_ist) ? WB_DAT_I[`WDIT_IRQ_W-1:0]
                                               : {`WDIT_IRQ_W{1'b0}};
   wire [`WDIT_IRQ_W-1:0] next_stat = ev | (irq_stat & ~w1c);

   always @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         irq_stat <= {`WDIT_IRQ_W{1'b0}};
         irq_mask <= {`WDIT_IRQ_W{1'b0}};
      end else begin
         irq_stat <= next_stat;
         if (wr && at_imk && WB_SEL_I[0]) begin
            irq_mask <= WB_DAT_I[`WDIT_IRQ_W-1:0];
         end
      end
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   wire [7:0] tcs_val = {ovf_flag, mode, enable, 2'b00, cks} | `WDIT_TCS_ONES;
   wire [7:0] rcs_val = {watchdog_overflow_flag_flag, chip_reset_enable, spare, 5'h00} | `WDIT_RCS_ONES;
   reg [31:0] next_dat;

   always @* begin
      next_dat = 32'h00000000;
      if (at_tcs) begin
         next_dat[7:0] = tcs_val;
      end else if (at_cnt) begin
         next_dat[7:0] = count;
      end else if (at_rcs) begin
         next_dat[7:0] = rcs_val;
      end else if (at_ist) begin
         next_dat[`WDIT_IRQ_W-1:0] = irq_stat;
      end else if (at_imk) begin
         next_dat[`WDIT_IRQ_W-1:0] = irq_mask;
      end
   end

   // ----------------------------------------
   // bus answer
   // ----------------------------------------
   // one wait state: ack rises the cycle after the request, drops after
   always @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h00000000;
      end else begin
         WB_ACK_O <= req & ~WB_ACK_O;
         if (req && !WB_ACK_O && !WB_WE_I) begin
            WB_DAT_O <= next_dat;
         end
      end
   end

   // ----------------------------------------
   // output flops
   // ----------------------------------------
   always @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         OVERFLOW_OUT_N <= 1'b1;
         CHIP_RESET_N <= 1'b1;
         INTERVAL_IRQ <= 1'b0;
         IRQ <= 1'b0;
      end else begin
         OVERFLOW_OUT_N <= ~ovf_pulse;
         CHIP_RESET_N <= ~rst_pulse;
         INTERVAL_IRQ <= ovf_flag;
         IRQ <= |(irq_stat & irq_mask);
      end
   end

endmodule

// *** hdl/wdit_regs.vh ***
/*
 what: register offsets, field positions, keys and timing counts of the
 watchdog / interval timer.
 assumes: classic wishbone slave with 32-bit data and byte addresses.
*/
// What this block does
// - 8-bit counter, runs only when enabled
// - clock select picks one of eight dividers
// - mode bit 6: 0 interval, 1 watchdog
// - interval wrap sets flag and interrupt
// - interval flag cleared by read-then-write-zero
// - watchdog wrap drives overflow pin low
// - watchdog flag set only by watchdog wrap
// - watchdog flag cleared by read-then-write-zero
// - reset enable picks chip or local reset
// - chip reset clears the interval flag
// - reset control loads 0x1f, only on pin reset
// - reserved bits read one, ignore writes
// - reset control bit 5 is plain storage
// - ordinary writes to timer registers rejected
// - pin low 132/130 states, reset 518 states
// - while pin low, protected writes and arming ignored
// - write beats increment in following cycle
`ifndef WDIT_REGS_VH
`define WDIT_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define WDIT_ADDR_W 8
`define WDIT_OFS_TCS 8'h00
`define WDIT_OFS_CNT 8'h04
`define WDIT_OFS_RCS 8'h08
`define WDIT_OFS_PWT 8'h0c
`define WDIT_OFS_PWR 8'h10
`define WDIT_OFS_IST 8'h14
`define WDIT_OFS_IMK 8'h18

// ----------------------------------------
// field positions
// ----------------------------------------
`define WDIT_FLAG_BIT 7
`define WDIT_MODE_BIT 6
`define WDIT_EN_BIT 5
`define WDIT_CHIP_RESET_ENABLE_BIT 6
`define WDIT_SPARE_BIT 5
`define WDIT_TCS_ONES 8'h18
`define WDIT_RCS_ONES 8'h1f
`define WDIT_RCS_RESET 8'h1f

// ----------------------------------------
// protected write keys (upper byte)
// ----------------------------------------
`define WDIT_KEY_CNT 8'h5a
`define WDIT_KEY_TCS 8'ha5
`define WDIT_KEY_CHIP_RESET_ENABLE 8'h5a
`define WDIT_KEY_CLRW 8'ha5

// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define WDIT_IRQ_W 2
`define WDIT_IRQ_IVL 0
`define WDIT_IRQ_WDG 1

// ----------------------------------------
// pulse lengths in states (one state = one clock)
// ----------------------------------------
`define WDIT_PULSE_W 10
`define WDIT_OVF_STATES_RST 10'h084
`define WDIT_OVF_STATES_NORST 10'h082
`define WDIT_CHIP_RST_STATES 10'h206
`define WDIT_DIV_W 17

`endif

// *** hdl/wdit_prescale.v ***
/*
 what: clock prescaler giving one increment strobe per selected period.
 assumes: single clock, divider held in clear while the timer is stopped.
*/
`timescale 1ns/1ns
`include "wdit_regs.vh"

module wdit_prescale #(
   parameter DIV_W = `WDIT_DIV_W
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // control
   input wire run,
   input wire [2:0] sel,
   // strobe
   output wire tick
);

   // ----------------------------------------
   // divider shift per select code
   // ----------------------------------------
   function integer shift_of;
      input integer code;
      begin
         case (code)
            0: shift_of = 1;
            1: shift_of = 6;
            2: shift_of = 7;
            3: shift_of = 9;
            4: shift_of = 11;
            5: shift_of = 13;
            6: shift_of = 15;
            default: shift_of = 17;
         endcase
      end
   endfunction

   reg [DIV_W-1:0] div;
   wire [7:0] tick_vec;

   // cleared while stopped so the first period after enable is whole
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div <= {DIV_W{1'b0}};
      end else if (!run) begin
         div <= {DIV_W{1'b0}};
      end else begin
         div <= div + {{(DIV_W-1){1'b0}}, 1'b1};
      end
   end

   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_sel
         localparam integer SH = shift_of(i);
         assign tick_vec[i] = &div[SH-1:0];
      end
   endgenerate

   assign tick = run & tick_vec[sel];

endmodule

// *** hdl/wdit_pulse.v ***
/*
 what: retriggerable-free pulse stretcher, active for a loaded count.
 assumes: start is a one-cycle strobe; a start during a pulse is ignored.
*/
`timescale 1ns/1ns
`include "wdit_regs.vh"

module wdit_pulse #(
   parameter W = `WDIT_PULSE_W
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // trigger
   input wire start,
   input wire [W-1:0] len,
   // pulse
   output reg active
);

   reg [W-1:0] left;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         left <= {W{1'b0}};
         active <= 1'b0;
      end else if (start && !active) begin
         left <= len - {{(W-1){1'b0}}, 1'b1};
         active <= 1'b1;
      end else if (active) begin
         if (left == {W{1'b0}}) begin
            active <= 1'b0;
         end else begin
            left <= left - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule

// *** dv/wdit_top_sva.sv ***
/*
 checker for the watchdog / interval timer port behaviour.
 assumes: bound to every wdit_top, sees only its ports.
*/
`timescale 1ns/1ns
module wdit_sva #(
   parameter AW = 8
) (
   // clock and reset
   input wire SYS_CLK,
   input wire NRST,
   // wishbone
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [AW-1:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   input wire [31:0] WB_DAT_O,
   input wire WB_ACK_O,
   // timer outputs
   input wire OVERFLOW_OUT_N,
   input wire CHIP_RESET_N,
   input wire INTERVAL_IRQ,
   input wire IRQ
);
default clocking @(posedge SYS_CLK); endclocking
default disable iff (!NRST);
// ----------------------------------------
// pulse length counters and write history
// ----------------------------------------
reg [9:0] low_cnt;
reg [9:0] rst_cnt;
reg [2:0] wr_hist;
always @(posedge SYS_CLK or negedge NRST) begin
   if (!NRST) begin
      low_cnt <= 10'h000;
      rst_cnt <= 10'h000;
      wr_hist <= 3'h0;
   end else begin
      low_cnt <= OVERFLOW_OUT_N ? 10'h000 : low_cnt + 10'h001;
      rst_cnt <= CHIP_RESET_N ? 10'h000 : rst_cnt + 10'h001;
      wr_hist <= {wr_hist[1:0], WB_ACK_O & WB_WE_I};
   end
end
// ----------------------------------------
// properties
// ----------------------------------------
property p_ack_next; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
property p_ack_one; WB_ACK_O |=> !WB_ACK_O; endproperty
property p_ack_cause; $rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I); endproperty
property p_dat_upper; WB_ACK_O && !WB_WE_I |-> WB_DAT_O[31:8] == 24'h000000; endproperty
// chip_reset_enable is not visible here: a running chip reset tells it
property p_ovf_len;
   $rose(OVERFLOW_OUT_N) |-> low_cnt == (CHIP_RESET_N ? 10'h082 : 10'h084);
endproperty
property p_ovf_min; $fell(OVERFLOW_OUT_N) |=> !OVERFLOW_OUT_N [*8]; endproperty
property p_chip_len; $rose(CHIP_RESET_N) |-> rst_cnt == 10'h206; endproperty
property p_chip_ovf; $fell(CHIP_RESET_N) |-> ##[0:3] !OVERFLOW_OUT_N; endproperty
property p_ivl_hold; $fell(INTERVAL_IRQ) |-> (|wr_hist) || !OVERFLOW_OUT_N; endproperty
a_ack_next: assert property (p_ack_next) else $error("ack missing");
a_ack_one: assert property (p_ack_one) else $error("ack too long");
a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
a_dat_upper: assert property (p_dat_upper) else $error("upper data set");
a_ovf_len: assert property (p_ovf_len) else $error("overflow pin length");
a_ovf_min: assert property (p_ovf_min) else $error("overflow pin short");
a_chip_len: assert property (p_chip_len) else $error("chip reset length");
a_chip_ovf: assert property (p_chip_ovf) else $error("chip reset alone");
a_ivl_hold: assert property (p_ivl_hold) else $error("flag lost");
c_ivl: cover property ($rose(INTERVAL_IRQ));
c_chip: cover property ($rose(CHIP_RESET_N));
c_local: cover property ($rose(OVERFLOW_OUT_N) && CHIP_RESET_N);
endmodule

bind wdit_top wdit_sva #(.AW(AW)) u_sva (.SYS_CLK(SYS_CLK), .NRST(NRST),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
   .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
   .OVERFLOW_OUT_N(OVERFLOW_OUT_N), .CHIP_RESET_N(CHIP_RESET_N),
   .INTERVAL_IRQ(INTERVAL_IRQ), .IRQ(IRQ));

// *** dv/wdit_top_test.sv ***
/*
 self-checking bench for wdit_top through its wishbone port.
 assumes: wdit_regs.vh on the include path; checker bound separately.
*/
`timescale 1ns/1ns
`include "wdit_regs.vh"
module wdit_top_test;
reg clk = 1'b0;
reg nrst = 1'b0;
reg req = 1'b0;
reg we = 1'b0;
reg [7:0] adr = 8'h00;
reg [3:0] sel = 4'h0;
reg [31:0] wdat = 32'h0;
wire [31:0] rdat;
wire ack, ovf_n, chip_n, ivl_irq, irq;
integer fail_count = 0;
integer tests_run = 0;
integer cycles = 0;
integer lo = 0;
integer cl = 0;
integer ovf_len = 0;
integer chip_len = 0;
integer i;
reg [31:0] rd;
always #5 clk = ~clk;
wdit_top dut (.SYS_CLK(clk), .NRST(nrst), .WB_CYC_I(req), .WB_STB_I(req),
   .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
   .WB_ACK_O(ack), .OVERFLOW_OUT_N(ovf_n), .CHIP_RESET_N(chip_n),
   .INTERVAL_IRQ(ivl_irq), .IRQ(irq));
// ----------------------------------------
// pulse measurement and hang guard
// ----------------------------------------
always @(posedge clk) begin
   cycles <= cycles + 1;
   lo <= ovf_n ? 0 : lo + 1;
   cl <= chip_n ? 0 : cl + 1;
   if (ovf_n && lo != 0) ovf_len <= lo;
   if (chip_n && cl != 0) chip_len <= cl;
   if (cycles == 60000) begin
      fail_count = fail_count + 1;
      complete_run;
   end
end
// ----------------------------------------
// tasks
// ----------------------------------------
task check(input [31:0] seen, input [31:0] exp);
   begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   end
endtask
task wb(input w, input [7:0] a, input [3:0] s, input [31:0] d);
   begin
      @(posedge clk);
      req <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      rd = rdat;
      req <= 1'b0;
   end
endtask
task rchk(input [7:0] a, input [31:0] e);
   begin
      wb(1'b0, a, 4'hf, 32'h0);
      check(rd, e);
   end
endtask
// protected word write: key in the upper byte, value in the lower
task pw(input [7:0] a, input [15:0] d);
   wb(1'b1, a, 4'h3, {16'h0, d});
endtask
task complete_run;
   begin
      $display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
      if (fail_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
endtask
// ----------------------------------------
// sequence
// ----------------------------------------
initial begin
   repeat (3) @(posedge clk);
   nrst <= 1'b1;
   rchk(`WDIT_OFS_TCS, 32'h18);
   rchk(`WDIT_OFS_CNT, 32'h00);
   rchk(`WDIT_OFS_RCS, 32'h1f);
   wb(1'b1, `WDIT_OFS_TCS, 4'hf, 32'h60);
   rchk(`WDIT_OFS_TCS, 32'h18);
   wb(1'b1, `WDIT_OFS_PWT, 4'h1, 32'ha560);
   rchk(`WDIT_OFS_TCS, 32'h18);
   pw(`WDIT_OFS_PWT, 16'h5a55);
   rchk(`WDIT_OFS_CNT, 32'h00);
   rchk(8'h1c, 32'h0);
   pw(`WDIT_OFS_PWR, 16'h5a3f);
   rchk(`WDIT_OFS_RCS, 32'h3f);
   // fast codes only: the slow dividers would dominate run time
   for (i = 1; i < 6; i = i + 1) begin
      pw(`WDIT_OFS_PWT, 16'ha520 | i[15:0]);
      repeat (3 << ((i < 3) ? i + 5 : 2 * i + 3)) @(posedge clk);
      rchk(`WDIT_OFS_CNT, 32'h03);
      pw(`WDIT_OFS_PWT, 16'ha500);
   end
   wb(1'b1, `WDIT_OFS_IMK, 4'hf, 32'h3);
   pw(`WDIT_OFS_PWT, 16'ha520);
   pw(`WDIT_OFS_PWT, 16'h5af0);
   wait (ivl_irq === 1'b1);
   repeat (2) @(posedge clk);
   check(irq, 32'h1);
   rchk(`WDIT_OFS_IST, 32'h01);
   rchk(`WDIT_OFS_RCS, 32'h3f);
   pw(`WDIT_OFS_PWT, 16'ha520);
   rchk(`WDIT_OFS_TCS, 32'hb8);
   pw(`WDIT_OFS_PWT, 16'ha500);
   rchk(`WDIT_OFS_TCS, 32'h18);
   check(ivl_irq, 32'h0);
   wb(1'b1, `WDIT_OFS_IMK, 4'hf, 32'h0);
   repeat (2) @(posedge clk);
   check(irq, 32'h0);
   wb(1'b1, `WDIT_OFS_IMK, 4'hf, 32'h3);
   repeat (2) @(posedge clk);
   check(irq, 32'h1);
   wb(1'b1, `WDIT_OFS_IST, 4'hf, 32'h1);
   repeat (2) @(posedge clk);
   check(irq, 32'h0);
   pw(`WDIT_OFS_PWR, 16'h5a60);
   pw(`WDIT_OFS_PWT, 16'ha560);
   pw(`WDIT_OFS_PWT, 16'h5af0);
   wait (ovf_n === 1'b0);
   pw(`WDIT_OFS_PWT, 16'ha560);
   rchk(`WDIT_OFS_TCS, 32'h18);
   rchk(`WDIT_OFS_RCS, 32'hff);
   wait (chip_n === 1'b1);
   repeat (2) @(posedge clk);
   check(ovf_len, 32'h84);
   check(chip_len, 32'h206);
   rchk(`WDIT_OFS_TCS, 32'h18);
   pw(`WDIT_OFS_PWR, 16'ha500);
   rchk(`WDIT_OFS_RCS, 32'hff);
   pw(`WDIT_OFS_PWR, 16'ha580);
   rchk(`WDIT_OFS_RCS, 32'hff);
   pw(`WDIT_OFS_PWR, 16'ha500);
   rchk(`WDIT_OFS_RCS, 32'h7f);
   rchk(`WDIT_OFS_IST, 32'h02);
   wb(1'b1, `WDIT_OFS_IST, 4'hf, 32'h2);
   pw(`WDIT_OFS_PWR, 16'h5a00);
   pw(`WDIT_OFS_PWT, 16'ha560);
   pw(`WDIT_OFS_PWT, 16'h5af0);
   wait (ovf_n === 1'b0);
   repeat (2) @(posedge clk);
   check(chip_n, 32'h1);
   wait (ovf_n === 1'b1);
   repeat (2) @(posedge clk);
   check(ovf_len, 32'h82);
   rchk(`WDIT_OFS_RCS, 32'h9f);
   nrst <= 1'b0;
   repeat (2) @(posedge clk);
   nrst <= 1'b1;
   rchk(`WDIT_OFS_RCS, 32'h1f);
   complete_run;
end
endmodule
